// ### include/ncsr_pkg.sv
// constants and register layout of the network configuration block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package ncsr_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONFIG   = 8'h00;
  localparam logic [7:0] OFS_SETUP1   = 8'h04;
  localparam logic [7:0] OFS_SUBADDR  = 8'h08;
  localparam logic [7:0] OFS_WINDOW   = 8'h0c;
  localparam logic [7:0] OFS_SETUP2   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_DIAG     = 8'h1c;
  // configuration field positions
  localparam int CFG_SCALE_LO  = 3;
  localparam int CFG_BACKPLANE = 2;
  // setup field positions
  localparam int SU_PULSE_TYPE = 7;
  localparam int SU_SHORT_LIM  = 6;
  localparam int SU_RESERVED   = 5;
  localparam int SU_PROMISC    = 4;
  localparam int SU_RATE_LO    = 1;
  localparam int SU_HALF_ARB   = 0;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_SETUP1 = 8'h06;
  localparam logic [7:0] RST_SETUP2 = 8'h00;
  localparam logic [7:0] RST_ID     = 8'h00;
  // refusal limits
  localparam logic [7:0] LIM_SHORT = 8'h04;
  localparam logic [7:0] LIM_LONG  = 8'h80;
  // clock and rate
  localparam int CLK_MHZ      = 200;
  localparam int XTAL_MHZ     = 20;
  localparam int XTAL_DIV     = CLK_MHZ / XTAL_MHZ;
  localparam logic [2:0] RATE_DEF_CODE = 3'h3;
  localparam logic [2:0] RATE_MAX_CODE = 3'h4;
  // timing figures at the default rate
  localparam int BIT_PERIOD_NS = 3200;
  localparam int RESP_TIME_US  = 9548;
  localparam int IDLE_TIME_US  = 10496;
  localparam int RECON_TIME_MS = 6720;
  localparam int RESP_TICKS  = (RESP_TIME_US * 1000 + BIT_PERIOD_NS - 1)
                               / BIT_PERIOD_NS;
  localparam int IDLE_TICKS  = (IDLE_TIME_US * 1000 + BIT_PERIOD_NS - 1)
                               / BIT_PERIOD_NS;
  localparam int RECON_TICKS = (RECON_TIME_MS * 1000 + BIT_PERIOD_NS - 1)
                               / BIT_PERIOD_NS * 1000;
  localparam int TMR_W = 23;
  // interrupt status bit positions
  localparam int IRQ_RESP   = 0;
  localparam int IRQ_IDLE   = 1;
  localparam int IRQ_RECON  = 2;
  localparam int IRQ_REFUSE = 3;
  localparam int IRQ_W      = 4;
  // window selections
  typedef enum logic [2:0] {
    SEL_TENTATIVE, SEL_NODE, SEL_SETUP1, SEL_NEXT, SEL_SETUP2,
    SEL_RSV5, SEL_RSV6, SEL_RSV7
  } ncsr_sel_e;
endpackage : ncsr_pkg

// ### src/ncsr_rate_prescaler.sv
// network tick prescaler from the system clock
`timescale 1ns/10ps
module ncsr_rate_prescaler
  import ncsr_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // rate selection
  input  wire logic [2:0] rate_code,
  // tick out
  output logic            net_tick
);
  logic [3:0] xtal_cnt;
  logic [6:0] div_cnt;
  logic       xtal_tick;
  logic [6:0] div_last;

  // divisor 8 << code, clamped at the slowest rate
  always_comb begin
    if (rate_code >= RATE_MAX_CODE) begin
      div_last = 7'h7f;
    end else begin
      div_last = 7'((8 << rate_code) - 1);
    end
  end

  // crystal rate strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      xtal_cnt  <= 4'h0;
      xtal_tick <= 1'b0;
    end else begin
      xtal_tick <= (xtal_cnt == 4'(XTAL_DIV - 1));
      xtal_cnt  <= (xtal_cnt == 4'(XTAL_DIV - 1)) ? 4'h0 : xtal_cnt + 4'h1;
    end
  end

  // data rate divider
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt  <= 7'h00;
      net_tick <= 1'b0;
    end else begin
      net_tick <= 1'b0;
      if (xtal_tick) begin
        if (div_cnt >= div_last) begin
          div_cnt  <= 7'h00;
          net_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 7'h01;
        end
      end
    end
  end
endmodule : ncsr_rate_prescaler

// ### src/ncsr_timeout_timer.sv
// one network timeout counted in prescaled ticks
`timescale 1ns/10ps
module ncsr_timeout_timer
  import ncsr_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // control
  input  wire logic             start,
  input  wire logic             tick,
  input  wire logic [TMR_W-1:0] length,
  // expiry pulse
  output logic                  expired
);
  logic [TMR_W-1:0] count;
  logic             running;

  // load on start, count ticks down, pulse at zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        count   <= length;
        running <= 1'b1;
      end else if (running && tick) begin
        if (count <= TMR_W'(1)) begin
          running <= 1'b0;
          count   <= '0;
          expired <= 1'b1;
        end else begin
          count <= count - TMR_W'(1);
        end
      end
    end
  end
endmodule : ncsr_timeout_timer

// ### src/ncsr_top.sv
// network configuration and setup registers with APB access
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module ncsr_top
  import ncsr_pkg::*;
#(
  parameter int RESP_LEN  = RESP_TICKS,
  parameter int IDLE_LEN  = IDLE_TICKS,
  parameter int RECON_LEN = RECON_TICKS
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // protocol engine timer requests
  input  wire logic       resp_start,
  input  wire logic       idle_start,
  input  wire logic       recon_start,
  // protocol engine refusal events
  input  wire logic       nack_seen,
  input  wire logic       refusal_clear,
  // received packet check
  input  wire logic       pkt_valid,
  input  wire logic [7:0] pkt_dest_id,
  input  wire logic [7:0] next_id_in,
  // transmit pulse request
  input  wire logic       tx_pulse,
  // timing outputs
  output logic            net_tick,
  output logic            resp_timeout,
  output logic            idle_timeout,
  output logic            recon_timeout,
  // packet decisions
  output logic            pkt_accept,
  output logic            pkt_ack,
  // configuration state
  output logic [7:0]      node_id,
  output logic            backplane_mode,
  output logic            excess_refusal_flag,
  // memory arbitration
  output logic            arb_strobe,
  output logic            mem_cycle_stretch,
  // line pulse pin
  output logic            line_pulse_one_output,
  output logic            line_pulse_one_oe_n,
  // interrupt
  output logic            irq
);
  //----------------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------------
  logic [7:0]        network_configuration;
  logic [7:0]        line_and_rate_setup;
  logic [7:0]        setup_two;
  logic              register_select_high;
  logic [7:0]        tentative_id;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [7:0]        refusal_count;
  logic              wr_en;
  logic              rd_setup;
  logic [7:0]        wbyte;
  logic [2:0]        win_sel;
  logic [1:0]        timeout_scale;
  logic [1:0]        reconfig_sel;
  logic [7:0]        refusal_limit;
  logic [TMR_W-1:0]  resp_len;
  logic [TMR_W-1:0]  idle_len;
  logic [TMR_W-1:0]  recon_len;
  logic [IRQ_W-1:0]  irq_events;
  logic [31:0]       next_prdata;
  logic              next_slverr;
  logic              arb_phase;
  logic              pulse_push_pull;

  // divide rounding upward by a power of two
  function automatic logic [TMR_W-1:0] ceil_shift(input int value,
                                                  input int shamt);
    int rounded;
    rounded = (value + (1 << shamt) - 1) >> shamt;
    return TMR_W'(rounded);
  endfunction : ceil_shift

  // true when an address hits a mapped register
  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == OFS_CONFIG || addr == OFS_SETUP1 ||
           addr == OFS_SUBADDR || addr == OFS_WINDOW ||
           addr == OFS_SETUP2 || addr == OFS_IRQ_STAT ||
           addr == OFS_IRQ_MASK || addr == OFS_DIAG;
  endfunction : is_mapped

  //----------------------------------------------------------------------------
  // bus decode
  //----------------------------------------------------------------------------
  // write lands at the access edge, read data prepared in setup
  assign wr_en    = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;
  assign wbyte    = pwdata[7:0];
  assign win_sel  = {register_select_high, network_configuration[1:0]};

  // field views
  assign timeout_scale   = network_configuration[CFG_SCALE_LO +: 2];
  assign reconfig_sel    = setup_two[1:0];
  assign pulse_push_pull = line_and_rate_setup[SU_PULSE_TYPE];

  //----------------------------------------------------------------------------
  // configuration registers
  //----------------------------------------------------------------------------
  // configuration plus the shared high select bit
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      network_configuration <= RST_CONFIG;
      register_select_high  <= 1'b0;
    end else if (wr_en) begin
      if (paddr == OFS_CONFIG) begin
        network_configuration <= wbyte;
        register_select_high  <= 1'b0;
      end else if (paddr == OFS_SUBADDR) begin
        network_configuration[1:0] <= wbyte[1:0];
        register_select_high       <= wbyte[2];
      end
    end
  end

  // setup register, direct or through the window
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      line_and_rate_setup <= RST_SETUP1;
    end else if (wr_en && (paddr == OFS_SETUP1 ||
                 (paddr == OFS_WINDOW && win_sel == SEL_SETUP1))) begin
      line_and_rate_setup <= wbyte;
      line_and_rate_setup[SU_RESERVED] <= 1'b0;
    end
  end

  // second setup register, direct or through the window
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      setup_two <= RST_SETUP2;
    end else if (wr_en && (paddr == OFS_SETUP2 ||
                 (paddr == OFS_WINDOW && win_sel == SEL_SETUP2))) begin
      setup_two <= wbyte;
    end
  end

  // identity registers behind the window
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tentative_id <= RST_ID;
      node_id      <= RST_ID;
    end else if (wr_en && paddr == OFS_WINDOW) begin
      if (win_sel == SEL_TENTATIVE) begin
        tentative_id <= wbyte;
      end
      if (win_sel == SEL_NODE) begin
        node_id <= wbyte;
      end
    end
  end

  //----------------------------------------------------------------------------
  // timeout lengths
  //----------------------------------------------------------------------------
  // response and idle scale by 1, 1/2, 1/4, 1/16 of the base
  always_comb begin
    unique case (timeout_scale)
      2'h0: begin
        resp_len = ceil_shift(RESP_LEN, 0);
        idle_len = ceil_shift(IDLE_LEN, 0);
      end
      2'h1: begin
        resp_len = ceil_shift(RESP_LEN, 1);
        idle_len = ceil_shift(IDLE_LEN, 1);
      end
      2'h2: begin
        resp_len = ceil_shift(RESP_LEN, 2);
        idle_len = ceil_shift(IDLE_LEN, 2);
      end
      2'h3: begin
        resp_len = ceil_shift(RESP_LEN, 4);
        idle_len = ceil_shift(IDLE_LEN, 4);
      end
    endcase
  end

  // reconfig from the select field, doubled unless fastest scale
  always_comb begin
    unique case (reconfig_sel)
      2'h0: recon_len = ceil_shift(RECON_LEN, 0);
      2'h1: recon_len = ceil_shift(RECON_LEN, 2);
      2'h2: recon_len = ceil_shift(RECON_LEN, 3);
      2'h3: recon_len = ceil_shift(RECON_LEN, 4);
    endcase
    if (timeout_scale != 2'h3) begin
      recon_len = TMR_W'({recon_len, 1'b0});
    end
  end

  //----------------------------------------------------------------------------
  // prescaler and timers
  //----------------------------------------------------------------------------
  ncsr_rate_prescaler u_prescaler (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .rate_code (line_and_rate_setup[SU_RATE_LO +: 3]),
    .net_tick  (net_tick)
  );

  ncsr_timeout_timer u_resp_timer (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (resp_start),
    .tick    (net_tick),
    .length  (resp_len),
    .expired (resp_timeout)
  );

  ncsr_timeout_timer u_idle_timer (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (idle_start),
    .tick    (net_tick),
    .length  (idle_len),
    .expired (idle_timeout)
  );

  ncsr_timeout_timer u_recon_timer (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (recon_start),
    .tick    (net_tick),
    .length  (recon_len),
    .expired (recon_timeout)
  );

  //----------------------------------------------------------------------------
  // refusal counting
  //----------------------------------------------------------------------------
  assign refusal_limit = line_and_rate_setup[SU_SHORT_LIM] ? LIM_SHORT
                                                           : LIM_LONG;

  // saturating count, flag set wins over clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      refusal_count       <= 8'h00;
      excess_refusal_flag <= 1'b0;
    end else begin
      if (nack_seen) begin
        if (refusal_count != 8'hff) begin
          refusal_count <= refusal_count + 8'h01;
        end
      end else if (refusal_clear) begin
        refusal_count <= 8'h00;
      end
      if (nack_seen && refusal_count + 8'h01 >= refusal_limit) begin
        excess_refusal_flag <= 1'b1;
      end else if (refusal_clear) begin
        excess_refusal_flag <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------------------
  // packet decisions
  //----------------------------------------------------------------------------
  // accept all when promiscuous, acknowledge own id only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pkt_accept <= 1'b0;
      pkt_ack    <= 1'b0;
    end else begin
      pkt_accept <= pkt_valid && (line_and_rate_setup[SU_PROMISC] ||
                    pkt_dest_id == node_id);
      pkt_ack    <= pkt_valid && pkt_dest_id == node_id;
    end
  end

  //----------------------------------------------------------------------------
  // line and arbitration outputs
  //----------------------------------------------------------------------------
  // pulse pin: open drain releases the line when idle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      backplane_mode        <= 1'b0;
      line_pulse_one_output <= 1'b1;
      line_pulse_one_oe_n   <= 1'b1;
    end else begin
      backplane_mode        <= network_configuration[CFG_BACKPLANE];
      line_pulse_one_output <= !tx_pulse;
      if (network_configuration[CFG_BACKPLANE] && !pulse_push_pull) begin
        line_pulse_one_oe_n <= !tx_pulse;
      end else begin
        line_pulse_one_oe_n <= 1'b0;
      end
    end
  end

  // arbitration strobe every cycle, or every second one when halved
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arb_phase         <= 1'b0;
      arb_strobe        <= 1'b0;
      mem_cycle_stretch <= 1'b0;
    end else begin
      arb_phase         <= !arb_phase;
      arb_strobe        <= !line_and_rate_setup[SU_HALF_ARB] ||
                           arb_phase;
      mem_cycle_stretch <= line_and_rate_setup[SU_HALF_ARB];
    end
  end

  //----------------------------------------------------------------------------
  // interrupts
  //----------------------------------------------------------------------------
  assign irq_events = {excess_refusal_flag, recon_timeout,
                       idle_timeout, resp_timeout};

  // sticky status, write one to clear, new event wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq        <= 1'b0;
    end else begin
      if (wr_en && paddr == OFS_IRQ_STAT) begin
        irq_status <= (irq_status & ~wbyte[IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
      if (wr_en && paddr == OFS_IRQ_MASK) begin
        irq_mask <= wbyte[IRQ_W-1:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  //----------------------------------------------------------------------------
  // read data
  //----------------------------------------------------------------------------
  // read mux, window follows the three select bits
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = !is_mapped(paddr);
    unique case (paddr)
      OFS_CONFIG:   next_prdata[7:0] = network_configuration;
      OFS_SETUP1:   next_prdata[7:0] = line_and_rate_setup;
      OFS_SUBADDR:  next_prdata[7:0] = {5'h00, win_sel};
      OFS_SETUP2:   next_prdata[7:0] = setup_two;
      OFS_IRQ_STAT: next_prdata[IRQ_W-1:0] = irq_status;
      OFS_IRQ_MASK: next_prdata[IRQ_W-1:0] = irq_mask;
      OFS_DIAG:     next_prdata[15:0] = {refusal_count, 7'h00,
                                         excess_refusal_flag};
      OFS_WINDOW: begin
        unique case (win_sel)
          SEL_TENTATIVE: next_prdata[7:0] = tentative_id;
          SEL_NODE:      next_prdata[7:0] = node_id;
          SEL_SETUP1:    next_prdata[7:0] = line_and_rate_setup;
          SEL_NEXT:      next_prdata[7:0] = next_id_in;
          SEL_SETUP2:    next_prdata[7:0] = setup_two;
          default:       next_prdata[7:0] = 8'h00;
        endcase
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // answer in the first access cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      if (rd_setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_slverr;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule : ncsr_top

// ### verification/ncsr_monitor.sv
// assertion checker on the configuration block ports
`timescale 1ns/10ps
module ncsr_monitor
  import ncsr_pkg::*;
(
  // clock, reset and apb answer
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // packet path
  input wire logic       pkt_valid,
  input wire logic [7:0] pkt_dest_id,
  input wire logic [7:0] node_id,
  input wire logic       pkt_accept,
  input wire logic       pkt_ack,
  // line pulse, refusals, tick and arbitration
  input wire logic       tx_pulse,
  input wire logic       line_pulse_one_output,
  input wire logic       line_pulse_one_oe_n,
  input wire logic       nack_seen,
  input wire logic       excess_refusal_flag,
  input wire logic       net_tick,
  input wire logic       mem_cycle_stretch,
  input wire logic       arb_strobe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // apb transfer steps
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; psel && penable && pready; endsequence
  property p_ready; s_setup |=> s_answer; endproperty
  a_ready: assert property (p_ready) else $error("late answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  // packet decisions one cycle after the packet
  property p_ack;
    1 |=> pkt_ack == $past(pkt_valid && pkt_dest_id == node_id);
  endproperty
  a_ack: assert property (p_ack) else $error("bad ack");
  property p_acc; pkt_accept |-> $past(pkt_valid); endproperty
  a_acc: assert property (p_acc) else $error("stray accept");
  property p_sub; pkt_ack |-> pkt_accept; endproperty
  a_sub: assert property (p_sub) else $error("ack unaccepted");
  // line pulse pin follows the request
  property p_line; line_pulse_one_output == !$past(tx_pulse); endproperty
  a_line: assert property (p_line) else $error("bad pulse");
  property p_oe; $past(tx_pulse) |-> !line_pulse_one_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("pin not driven");
  property p_flag; $rose(excess_refusal_flag) |-> $past(nack_seen); endproperty
  a_flag: assert property (p_flag) else $error("flag uncaused");
  property p_tick; net_tick |=> !net_tick [*7]; endproperty
  a_tick: assert property (p_tick) else $error("tick too fast");
  property p_arb_fast; !mem_cycle_stretch [*3] |-> arb_strobe; endproperty
  a_arb_fast: assert property (p_arb_fast) else $error("arb gap");
  property p_arb_slow;
    mem_cycle_stretch [*3] |-> arb_strobe != $past(arb_strobe);
  endproperty
  a_arb_slow: assert property (p_arb_slow) else $error("arb full");
endmodule : ncsr_monitor

bind ncsr_top ncsr_monitor u_mon (.*);

// ### verification/ncsr_net_model.sv
// network side stand-in: refusals, received packets, next node id
`timescale 1ns/10ps
module ncsr_net_model (
  // clock
  input  wire logic clk_sys,
  // engine events towards the block
  output logic       nack_seen,
  output logic       pkt_valid,
  output logic [7:0] pkt_dest_id,
  output logic [7:0] next_id_in
);
  // quiet engine at start
  initial begin
    nack_seen   = 1'b0;
    pkt_valid   = 1'b0;
    pkt_dest_id = 8'h00;
    next_id_in  = 8'h3c;
  end
  // refusals to buffer enquiries, one every other cycle
  task automatic refuse(input int n);
    repeat (n) begin
      nack_seen <= 1'b1;
      @(posedge clk_sys);
      nack_seen <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : refuse
  // one valid packet; the id lines invert once it is gone
  task automatic packet(input logic [7:0] dest);
    pkt_valid   <= 1'b1;
    pkt_dest_id <= dest;
    @(posedge clk_sys);
    pkt_valid   <= 1'b0;
    pkt_dest_id <= ~dest;
    @(posedge clk_sys);
  endtask : packet
endmodule : ncsr_net_model

// ### verification/tb_top.sv
// self-checking bench for the configuration and setup registers
`timescale 1ns/10ps
module tb_top;
  import ncsr_pkg::*;
  logic        clk_sys       = 1'b0;
  logic        rstn          = 1'b0;
  logic        psel, penable, pwrite, resp_start, idle_start, recon_start;
  logic        refusal_clear, tx_pulse, idle_timeout, recon_timeout;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  pkt_dest_id, next_id_in, node_id;
  logic        pready, pslverr, nack_seen, pkt_valid, net_tick, e, irq;
  logic        resp_timeout, pkt_accept, pkt_ack, backplane_mode;
  logic        excess_refusal_flag, arb_strobe, mem_cycle_stretch;
  logic        line_pulse_one_output, line_pulse_one_oe_n;
  logic [31:0] wexp [4] = '{32'h77, 32'h5a, 32'h06, 32'h3c};
  int          miscompares = 0;
  int          compares    = 0;
  int          cycles      = 0;

  always #2.5 clk_sys = ~clk_sys;
  ncsr_net_model m (.*);
  ncsr_top #(.RESP_LEN(32), .IDLE_LEN(48), .RECON_LEN(64)) DUT (.*);

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] x, y);
    compares++;
    if (y !== x) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, x, y);
    end
  endtask : cmp
  task automatic bit1(input string nm, input logic x, y);
    cmp(nm, {31'h0, x}, {31'h0, y});
  endtask : bit1
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, logic [31:0] x);
    apb(1'b0, a, 8'h00);
    cmp(nm, x, q);
  endtask : rd
  // cycles between two network ticks
  task automatic gap(input string nm, input int x);
    int n = 1;
    @(posedge clk_sys);
    while (net_tick !== 1'b1) @(posedge clk_sys);
    @(posedge clk_sys);
    while (net_tick !== 1'b1) begin
      n++;
      @(posedge clk_sys);
    end
    cmp(nm, x, n);
  endtask : gap
  // start all three timers, ticks counted up to each expiry
  task automatic tmr();
    int r = 0, i = 0, c = 0, t = 0;
    {resp_start, idle_start, recon_start} <= 3'h7;
    @(posedge clk_sys);
    {resp_start, idle_start, recon_start} <= 3'h0;
    while (r == 0 || i == 0 || c == 0) begin
      @(posedge clk_sys);
      if (resp_timeout) r = t;
      if (idle_timeout) i = t;
      if (recon_timeout) c = t;
      t += net_tick;
    end
    q = {r[7:0], i[7:0], c[15:0]};
  endtask : tmr
  task automatic clr();
    refusal_clear <= 1'b1;
    @(posedge clk_sys);
    refusal_clear <= 1'b0;
    @(posedge clk_sys);
  endtask : clr

  initial begin
    {psel, penable, pwrite, paddr, pwdata, tx_pulse} <= '0;
    {resp_start, idle_start, recon_start, refusal_clear} <= '0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    rd("config", OFS_CONFIG, 32'h0);
    rd("setup", OFS_SETUP1, 32'h06);
    rd("mask", OFS_IRQ_MASK, 32'h0);
    rd("hole", 8'h20, 32'h0);
    bit1("hole err", 1'b1, e);
    // window selections
    wr(OFS_CONFIG, 8'h04);
    wr(OFS_WINDOW, 8'h77);
    wr(OFS_CONFIG, 8'h05);
    wr(OFS_WINDOW, 8'h5a);
    cmp("node", 32'h5a, {24'h0, node_id});
    bit1("backplane", 1'b1, backplane_mode);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CONFIG, 8'h04 | s[7:0]);
      rd("window", OFS_WINDOW, wexp[s]);
    end
    wr(OFS_SUBADDR, 8'h04);
    wr(OFS_CONFIG, 8'h05);
    rd("subaddr", OFS_SUBADDR, 32'h01);
    // open drain then push-pull pulse pin
    tx_pulse <= 1'b1;
    repeat (2) @(posedge clk_sys);
    bit1("oe drive", 1'b0, line_pulse_one_oe_n);
    tx_pulse <= 1'b0;
    repeat (2) @(posedge clk_sys);
    bit1("oe open", 1'b1, line_pulse_one_oe_n);
    wr(OFS_SETUP1, 8'ha6);
    rd("setup rsv", OFS_SETUP1, 32'h86);
    bit1("oe push", 1'b0, line_pulse_one_oe_n);
    // refusal limits four and 128
    wr(OFS_SETUP1, 8'h46);
    m.refuse(3);
    bit1("flag 3", 1'b0, excess_refusal_flag);
    m.refuse(1);
    bit1("flag 4", 1'b1, excess_refusal_flag);
    rd("diag", OFS_DIAG, 32'h0401);
    clr();
    wr(OFS_SETUP1, 8'h06);
    m.refuse(127);
    bit1("flag 127", 1'b0, excess_refusal_flag);
    m.refuse(1);
    bit1("flag 128", 1'b1, excess_refusal_flag);
    clr();
    // packet acceptance
    m.packet(8'h5a);
    bit1("ack own", 1'b1, pkt_ack);
    m.packet(8'h11);
    bit1("acc other", 1'b0, pkt_accept);
    wr(OFS_SETUP1, 8'h16);
    m.packet(8'h11);
    bit1("acc all", 1'b1, pkt_accept);
    bit1("ack other", 1'b0, pkt_ack);
    // data rates and arbitration
    wr(OFS_SETUP1, 8'h06);
    gap("tick 011", XTAL_DIV * 64);
    wr(OFS_SETUP1, 8'h08);
    gap("tick 100", XTAL_DIV * 128);
    wr(OFS_SETUP1, 8'h0e);
    gap("tick 111", XTAL_DIV * 128);
    wr(OFS_SETUP1, 8'h07);
    // all three timeouts by scale code and reconfig select, then interrupt
    wr(OFS_SETUP1, 8'h00);
    bit1("stretch", 1'b1, mem_cycle_stretch);
    wr(OFS_CONFIG, 8'h04);
    tmr();
    cmp("tmr 00", 32'h2030_0080, q);
    wr(OFS_CONFIG, 8'h1c);
    tmr();
    cmp("tmr 11", 32'h0203_0040, q);
    wr(OFS_IRQ_STAT, 8'h0f);
    wr(OFS_SETUP2, 8'h03);
    tmr();
    cmp("tmr sel", 32'h0203_0004, q);
    rd("status", OFS_IRQ_STAT, 32'h07);
    bit1("irq masked", 1'b0, irq);
    wr(OFS_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_sys);
    bit1("irq on", 1'b1, irq);
    wr(OFS_IRQ_STAT, 8'h01);
    repeat (2) @(posedge clk_sys);
    bit1("irq off", 1'b0, irq);
    end_of_test();
  end
endmodule : tb_top
